// [rtl/switch_cmd_pkg.sv]
/*
  Constants for the six-channel switch serial command decoder.
  Assumes the link clock is the serial clock, data sampled on its rise.
*/
package switch_cmd_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CMD_MSB    = 15;
  localparam int CMD_LSB    = 12;
  localparam logic [3:0] CMD_REG1    = 4'h9;
  localparam logic [3:0] CMD_REG2    = 4'ha;
  localparam logic [3:0] CMD_REG3    = 4'hb;
  localparam logic [3:0] CMD_CHCFG   = 4'hc;
  localparam logic [3:0] CMD_DEFAULT = 4'h8;
  localparam logic [3:0] CMD_DIAG    = 4'hf;
  localparam logic [3:0] CMD_SWITCH  = 4'hd;
  // Regulator field positions inside the frame
  localparam int MODE_POS = 10;
  localparam int PEAK_POS = 8;
  localparam int OFF_POS  = 6;
  localparam int HOLD_POS = 4;
  localparam int PTIM_POS = 1;
  // Channel config positions
  localparam int SIDE6_POS = 11;
  localparam int DET6_POS  = 10;
  localparam int SIDE5_POS = 9;
  localparam int DET5_POS  = 8;
  localparam int SIDE4_POS = 7;
  localparam int DET4_POS  = 6;
  localparam int BOOL_POS  = 5;
  localparam int OTB_POS   = 4;
  localparam int PINS_POS  = 3;
  localparam int ON_LSB    = 6;
  // Encodings
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_HOLD = 2'h1;
  localparam logic [1:0] MODE_MINP = 2'h2;
  localparam logic [1:0] MODE_PROG = 2'h3;
  localparam logic [1:0] PEAK_2A4  = 2'h2;
  localparam logic [1:0] PEAK_3A6  = 2'h3;
  localparam logic [1:0] HOLD_0A7  = 2'h0;
  localparam logic [1:0] HOLD_1A0  = 2'h1;
  localparam logic [1:0] HOLD_1A4  = 2'h2;
  localparam logic [1:0] HOLD_2A0  = 2'h3;
  localparam logic [1:0] OFF_100US = 2'h0;
  localparam logic [1:0] OFF_200US = 2'h1;
  localparam logic [1:0] OFF_300US = 2'h2;
  localparam logic [1:0] OFF_400US = 2'h3;
  localparam logic [2:0] PTIM_0M8  = 3'h0;
  localparam logic [2:0] PTIM_2M8  = 3'h6;
  localparam logic [2:0] PTIM_3M6  = 3'h7;
  // Reset values
  localparam logic [1:0] MODE_RST = MODE_NONE;
  localparam logic [1:0] PEAK_RST = PEAK_2A4;
  localparam logic [1:0] HOLD_RST = HOLD_1A0;
  localparam logic [1:0] OFF_RST  = OFF_200US;
  localparam logic [2:0] PTIM_RST = PTIM_2M8;
  localparam logic [2:0] SIDE_RST = 3'h0;
  localparam logic [2:0] DET_RST  = 3'h0;
  localparam logic       BOOL_RST = 1'b0;
  localparam logic       OTB_RST  = 1'b0;
  localparam logic       PINS_RST = 1'b0;
  localparam logic [5:0] ON_RST   = 6'h00;
endpackage

// [rtl/switch_spi_command_decoder.sv]
/*
  Serial command decoder: shift register on the serial clock, frame
  handed to core_clk by a toggle handshake and executed there.
  Assumes chip select and serial data are quiet while sclk runs only in
  frames; sclk stops outside frames.
*/
`timescale 1ns/1ps
module switch_spi_command_decoder
  import switch_cmd_pkg::*;
(
  // Core clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // Serial link
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  // Regulator settings, channels one to three
  output logic [5:0]      mode_sel,
  output logic [5:0]      peak_current_sel,
  output logic [5:0]      hold_current_sel,
  output logic [5:0]      fixed_off_time_sel,
  output logic [8:0]      peak_time_sel,
  // Channel configuration
  output logic [2:0]      low_side_sel,
  output logic [2:0]      openload_bypass_detect_disable,
  output logic            bool_and_sel,
  output logic            overtemp_latch_sel,
  output logic            channel_six_diag_pin,
  output logic [5:0]      channel_on_bits,
  // Diagnosis control
  output logic            diag_clear,
  output logic            cmd_valid_seen
);
  import switch_cmd_pkg::*;

  // Frame toggle, flipped by each cs_n rise; the link side reads it too
  // to spot the first bit of a new frame. It only moves while sclk is
  // stopped, so it is settled long before the next serial edge.
  logic                  frame_tgl_reg;
  logic                  seen_tgl_reg;
  wire                   new_frame = (seen_tgl_reg != frame_tgl_reg);

  // Bit count: restarts on a new frame, saturates on long frames
  function automatic logic [4:0] next_count(input logic [4:0] c,
                                            input logic       restart);
    if (restart)
      next_count = 5'h01;
    else if (c == 5'h1f)
      next_count = c;
    else
      next_count = c + 5'h01;
  endfunction

  // Link domain: shift in MSB first on the rising serial clock. The count
  // restarts at the first bit after each cs_n rise because sclk gives no
  // edge to clear it on between frames.
  logic [FRAME_BITS-1:0] shift_reg;
  logic [4:0]            count_reg;
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg    <= '0;
      count_reg    <= '0;
      seen_tgl_reg <= 1'b0;
    end else if (!cs_n) begin
      shift_reg    <= {shift_reg[FRAME_BITS-2:0], sdi};
      seen_tgl_reg <= frame_tgl_reg;
      count_reg    <= next_count(count_reg, new_frame);
    end
  end

  // Capture the frame and its length check on cs_n rise; sclk is
  // stopped then, so cs_n itself is the only edge available
  logic [FRAME_BITS-1:0] frame_reg;
  logic                  frame_ok_reg;
  always_ff @(posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      frame_reg     <= '0;
      frame_ok_reg  <= 1'b0;
      frame_tgl_reg <= 1'b0;
    end else begin
      frame_reg     <= shift_reg;
      frame_ok_reg  <= (count_reg == 5'(FRAME_BITS));
      frame_tgl_reg <= ~frame_tgl_reg;
    end
  end

  // Core domain: synchronise toggle, data is stable by then
  logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else if (clk_en) begin
      tgl_s1_reg <= frame_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  wire       frame_evt = clk_en && (tgl_s2_reg != tgl_s3_reg);
  wire [3:0] cmd       = frame_reg[CMD_MSB:CMD_LSB];

  // Command decode
  function automatic logic cmd_known(input logic [3:0] c);
    cmd_known = (c == CMD_REG1) || (c == CMD_REG2) || (c == CMD_REG3) ||
                (c == CMD_CHCFG) || (c == CMD_DEFAULT) ||
                (c == CMD_DIAG) || (c == CMD_SWITCH);
  endfunction

  wire valid_evt  = frame_evt && frame_ok_reg && cmd_known(cmd);
  wire do_reg1    = valid_evt && (cmd == CMD_REG1);
  wire do_reg2    = valid_evt && (cmd == CMD_REG2);
  wire do_reg3    = valid_evt && (cmd == CMD_REG3);
  wire do_chcfg   = valid_evt && (cmd == CMD_CHCFG);
  wire do_default = valid_evt && (cmd == CMD_DEFAULT);
  wire do_switch  = valid_evt && (cmd == CMD_SWITCH);
  // Diagnosis-only falls through: no register write

  wire [1:0] f_mode = frame_reg[MODE_POS+1:MODE_POS];
  wire [1:0] f_peak = frame_reg[PEAK_POS+1:PEAK_POS];
  wire [1:0] f_off  = frame_reg[OFF_POS+1:OFF_POS];
  wire [1:0] f_hold = frame_reg[HOLD_POS+1:HOLD_POS];
  wire [2:0] f_ptim = frame_reg[PTIM_POS+2:PTIM_POS];
  wire [2:0] f_side = {frame_reg[SIDE6_POS], frame_reg[SIDE5_POS],
                       frame_reg[SIDE4_POS]};
  wire [2:0] f_det  = {frame_reg[DET6_POS], frame_reg[DET5_POS],
                       frame_reg[DET4_POS]};
  wire [5:0] f_on   = frame_reg[ON_LSB+5:ON_LSB];

  // Regulator registers, one slice per channel; a single process owns
  // every slice so no output has more than one writer
  wire [2:0] reg_wr = {do_reg3, do_reg2, do_reg1};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_sel           <= {3{MODE_RST}};
      peak_current_sel   <= {3{PEAK_RST}};
      hold_current_sel   <= {3{HOLD_RST}};
      fixed_off_time_sel <= {3{OFF_RST}};
      peak_time_sel      <= {3{PTIM_RST}};
    end else if (do_default) begin
      mode_sel           <= {3{MODE_RST}};
      peak_current_sel   <= {3{PEAK_RST}};
      hold_current_sel   <= {3{HOLD_RST}};
      fixed_off_time_sel <= {3{OFF_RST}};
      peak_time_sel      <= {3{PTIM_RST}};
    end else begin
      for (int g = 0; g < 3; g++) begin
        if (reg_wr[g]) begin
          mode_sel[2*g+:2]           <= f_mode;
          peak_current_sel[2*g+:2]   <= f_peak;
          hold_current_sel[2*g+:2]   <= f_hold;
          fixed_off_time_sel[2*g+:2] <= f_off;
          peak_time_sel[3*g+:3]      <= f_ptim;
        end
      end
    end
  end

  // Channel configuration and on bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_side_sel                   <= SIDE_RST;
      openload_bypass_detect_disable <= DET_RST;
      bool_and_sel                   <= BOOL_RST;
      overtemp_latch_sel             <= OTB_RST;
      channel_six_diag_pin           <= PINS_RST;
      channel_on_bits                <= ON_RST;
    end else if (do_default) begin
      low_side_sel                   <= SIDE_RST;
      openload_bypass_detect_disable <= DET_RST;
      bool_and_sel                   <= BOOL_RST;
      overtemp_latch_sel             <= OTB_RST;
      channel_six_diag_pin           <= PINS_RST;
      channel_on_bits                <= ON_RST;
    end else begin
      if (do_chcfg) begin
        low_side_sel                   <= f_side;
        openload_bypass_detect_disable <= f_det;
        bool_and_sel                   <= frame_reg[BOOL_POS];
        overtemp_latch_sel             <= frame_reg[OTB_POS];
        channel_six_diag_pin           <= frame_reg[PINS_POS];
      end
      if (do_switch)
        channel_on_bits <= f_on;
    end
  end

  // Diagnosis clear pulse; the diagnosis block keeps its overtemp flag
  // and restarts its filter on this pulse
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_clear     <= 1'b0;
      cmd_valid_seen <= 1'b0;
    end else if (clk_en) begin
      diag_clear     <= valid_evt;
      cmd_valid_seen <= cmd_valid_seen | valid_evt;
    end
  end

  // Checks on the clear pulse and frame acceptance. A frozen core holds
  // diag_clear, so the pulse checks only look across enabled edges.
  AST_CLEAR_ONLY_VALID: assert property (@(posedge core_clk)
    disable iff (!rst_n) diag_clear && $past(clk_en) |-> $past(valid_evt))
    else $error("diag clear without valid frame");
  AST_VALID_CLEARS: assert property (@(posedge core_clk)
    disable iff (!rst_n) valid_evt |=> diag_clear)
    else $error("valid frame did not clear diagnosis");
  AST_CLEAR_ONE_CYCLE: assert property (@(posedge core_clk)
    disable iff (!rst_n) diag_clear && clk_en |=> !diag_clear)
    else $error("diag clear longer than one cycle");
  AST_EVT_SPACING: assert property (@(posedge core_clk)
    disable iff (!rst_n) frame_evt |=> !frame_evt)
    else $error("one frame seen twice");
  AST_SEEN_SET: assert property (@(posedge core_clk)
    disable iff (!rst_n) valid_evt |=> cmd_valid_seen)
    else $error("valid frame not recorded");
  AST_SEEN_STICKY: assert property (@(posedge core_clk)
    disable iff (!rst_n) cmd_valid_seen |=> cmd_valid_seen)
    else $error("valid frame record lost");
  AST_IDLE_NO_WRITE: assert property (@(posedge core_clk)
    disable iff (!rst_n) !frame_evt |=> $stable(mode_sel) &&
    $stable(channel_on_bits) && $stable(low_side_sel))
    else $error("settings changed without a frame");
  AST_ONE_DECODE: assert property (@(posedge core_clk)
    disable iff (!rst_n) $onehot0({do_reg1, do_reg2, do_reg3, do_chcfg,
    do_default, do_switch}))
    else $error("more than one command decoded");

  // Refused frames: wrong length or unassigned code do nothing
  AST_BAD_NO_CLEAR: assert property (@(posedge core_clk)
    disable iff (!rst_n) frame_evt && !valid_evt |=> !diag_clear)
    else $error("invalid frame cleared diagnosis");
  AST_BAD_KEEP: assert property (@(posedge core_clk)
    disable iff (!rst_n) (frame_evt && !valid_evt) |=>
    $stable(bool_and_sel) && $stable(low_side_sel))
    else $error("invalid frame changed state");
  AST_BAD_KEEP_REG: assert property (@(posedge core_clk)
    disable iff (!rst_n) (frame_evt && !valid_evt) |=> $stable(mode_sel)
    && $stable(peak_time_sel) && $stable(channel_on_bits))
    else $error("invalid frame changed regulator or on bits");
  AST_SHORT_REFUSED: assert property (@(posedge core_clk)
    disable iff (!rst_n) frame_evt && !frame_ok_reg |=>
    $stable(channel_on_bits) && !diag_clear)
    else $error("frame of wrong length accepted");

  // Regulator configuration commands
  AST_REG1_LOAD: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_reg1 |=> mode_sel[1:0] == $past(f_mode))
    else $error("regulator one mode not loaded");
  AST_REG2_LOAD: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_reg2 |=> mode_sel[3:2] == $past(f_mode))
    else $error("regulator two mode not loaded");
  AST_REG3_LOAD: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_reg3 |=> mode_sel[5:4] == $past(f_mode))
    else $error("regulator three mode not loaded");
  AST_MODE_PROG: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_reg1 && f_mode == MODE_PROG |=>
    mode_sel[1:0] == MODE_PROG)
    else $error("programmed peak mode not kept");
  AST_REG1_PEAK: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_reg1 |=> peak_current_sel[1:0] == $past(f_peak))
    else $error("regulator one peak current not loaded");
  AST_REG2_PEAK: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_reg2 |=> peak_current_sel[3:2] == $past(f_peak))
    else $error("regulator two peak current not loaded");
  AST_REG1_HOLD: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_reg1 |=> hold_current_sel[1:0] == $past(f_hold))
    else $error("regulator one hold current not loaded");
  AST_REG3_HOLD: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_reg3 |=> hold_current_sel[5:4] == $past(f_hold))
    else $error("regulator three hold current not loaded");
  AST_REG1_OFF: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_reg1 |=> fixed_off_time_sel[1:0] == $past(f_off))
    else $error("regulator one off time not loaded");
  AST_REG2_OFF: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_reg2 |=> fixed_off_time_sel[3:2] == $past(f_off))
    else $error("regulator two off time not loaded");
  AST_REG1_PTIM: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_reg1 |=> peak_time_sel[2:0] == $past(f_ptim))
    else $error("regulator one peak time not loaded");
  AST_REG3_PTIM: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_reg3 |=> peak_time_sel[8:6] == $past(f_ptim))
    else $error("regulator three peak time not loaded");
  AST_REG1_ONLY: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_reg1 |=> $stable(mode_sel[5:2]) &&
    $stable(peak_time_sel[8:3]))
    else $error("regulator one command touched another regulator");
  AST_REG_KEEP_CFG: assert property (@(posedge core_clk)
    disable iff (!rst_n) (do_reg1 || do_reg2 || do_reg3) |=>
    $stable(low_side_sel) && $stable(channel_on_bits))
    else $error("regulator command touched channel settings");

  // Channel configuration command
  AST_CHCFG_SIDE: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_chcfg |=> low_side_sel == $past(f_side))
    else $error("side selects not loaded");
  AST_CHCFG_DET: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_chcfg |=>
    openload_bypass_detect_disable == $past(f_det))
    else $error("detection bits not loaded");
  AST_CHCFG_BOOL: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_chcfg |=>
    bool_and_sel == $past(frame_reg[BOOL_POS]))
    else $error("boolean bit not loaded");
  AST_CHCFG_OTB: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_chcfg |=>
    overtemp_latch_sel == $past(frame_reg[OTB_POS]))
    else $error("overtemperature bit not loaded");
  AST_CHCFG_PIN: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_chcfg |=>
    channel_six_diag_pin == $past(frame_reg[PINS_POS]))
    else $error("pin select not loaded");
  AST_CHCFG_KEEP: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_chcfg |=> $stable(channel_on_bits) &&
    $stable(mode_sel))
    else $error("channel command touched other settings");

  // Channel switching command
  AST_SWITCH_LOAD: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_switch |=> channel_on_bits == $past(f_on))
    else $error("on bits not loaded");
  AST_SWITCH_KEEP: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_switch |=> $stable(low_side_sel) &&
    $stable(mode_sel))
    else $error("switching command touched configuration");

  // Restore-defaults command
  AST_DEFAULT_MODE: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_default |=> mode_sel == {3{MODE_RST}})
    else $error("default did not clear modes");
  AST_DEFAULT_PEAK: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_default |=> peak_current_sel == {3{PEAK_RST}})
    else $error("default peak current wrong");
  AST_DEFAULT_HOLD: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_default |=> hold_current_sel == {3{HOLD_RST}})
    else $error("default hold current wrong");
  AST_DEFAULT_OFF: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_default |=> fixed_off_time_sel == {3{OFF_RST}})
    else $error("default off time wrong");
  AST_DEFAULT_PTIM: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_default |=> peak_time_sel == {3{PTIM_RST}})
    else $error("default peak time wrong");
  AST_DEFAULT_ON: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_default |=> channel_on_bits == ON_RST)
    else $error("default left channels on");
  AST_DEFAULT_CFG: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_default |=> low_side_sel == SIDE_RST &&
    openload_bypass_detect_disable == DET_RST)
    else $error("default channel configuration wrong");
  AST_DEFAULT_GLOBAL: assert property (@(posedge core_clk)
    disable iff (!rst_n) do_default |=> bool_and_sel == BOOL_RST &&
    overtemp_latch_sel == OTB_RST && channel_six_diag_pin == PINS_RST)
    else $error("default global bits wrong");

  // Diagnosis-only command: clears diagnosis, writes nothing
  AST_DIAG_KEEP: assert property (@(posedge core_clk)
    disable iff (!rst_n) (valid_evt && cmd == CMD_DIAG) |=>
    $stable(channel_on_bits) && $stable(mode_sel))
    else $error("diagnosis command changed state");
  AST_DIAG_KEEP_CFG: assert property (@(posedge core_clk)
    disable iff (!rst_n) (valid_evt && cmd == CMD_DIAG) |=>
    $stable(low_side_sel) && $stable(peak_time_sel))
    else $error("diagnosis command changed configuration");
  AST_DIAG_CLEARS: assert property (@(posedge core_clk)
    disable iff (!rst_n) (valid_evt && cmd == CMD_DIAG) |=> diag_clear)
    else $error("diagnosis command did not clear");

  // Main scenarios
  COV_SWITCH: cover property (@(posedge core_clk) do_switch);
  COV_CHCFG: cover property (@(posedge core_clk) do_chcfg);
  COV_DEFAULT: cover property (@(posedge core_clk) do_default);
  COV_INVALID: cover property (@(posedge core_clk) frame_evt && !valid_evt);
  COV_DIAG: cover property (@(posedge core_clk) valid_evt && cmd == CMD_DIAG);
endmodule

// [verification/spi_host_model.sv]
/*
  Host controller model: serial master that feeds command frames.
  Assumes the caller spaces frames; the serial clock stops between them.
*/
`timescale 1ns/1ps
module spi_host_model (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // Sends the top n bits of f, MSB first, 64 ns per bit
  task automatic send(input logic [15:0] f, input int n);
    #13.7 cs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      sdi = f[i];
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #20 cs_n = 1'b1;
    sdi = ~sdi; // Released line must not keep its last value
  endtask
endmodule

// [verification/switch_spi_command_decoder_bench.sv]
/*
  Self-checking bench for the serial command decoder.
  Assumes the host model owns the link; the bench imports the package constants.
*/
`timescale 1ns/1ps
module switch_spi_command_decoder_bench;
  import switch_cmd_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        clk_en   = 1'b1;
  wire logic   sclk, cs_n, sdi;
  logic [5:0]  mode_sel, peak_current_sel, hold_current_sel;
  logic [5:0]  fixed_off_time_sel, channel_on_bits;
  logic [8:0]  peak_time_sel;
  logic [2:0]  low_side_sel, openload_bypass_detect_disable;
  logic        bool_and_sel, overtemp_latch_sel, channel_six_diag_pin;
  logic        diag_clear, cmd_valid_seen;
  logic [5:0]  e_mode, e_peak, e_hold, e_off, e_on;
  logic [8:0]  e_pt;
  logic [2:0]  e_low, e_det;
  logic        e_bool, e_otb, e_pin, e_seen;
  int          error_cnt   = 0;
  int          check_count = 0;
  int          dc_cnt      = 0;
  int          p0          = 0;
  wire logic [48:0] want_outs = {e_mode, e_peak, e_hold, e_off, e_pt,
    e_low, e_det, e_bool, e_otb, e_pin, e_on, e_seen};
  wire logic [48:0] outs = {mode_sel, peak_current_sel, hold_current_sel,
    fixed_off_time_sel, peak_time_sel, low_side_sel,
    openload_bypass_detect_disable, bool_and_sel, overtemp_latch_sel,
    channel_six_diag_pin, channel_on_bits, cmd_valid_seen};

  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi));

  switch_spi_command_decoder uut (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .mode_sel(mode_sel), .peak_current_sel(peak_current_sel),
    .hold_current_sel(hold_current_sel),
    .fixed_off_time_sel(fixed_off_time_sel),
    .peak_time_sel(peak_time_sel), .low_side_sel(low_side_sel),
    .openload_bypass_detect_disable(openload_bypass_detect_disable),
    .bool_and_sel(bool_and_sel), .overtemp_latch_sel(overtemp_latch_sel),
    .channel_six_diag_pin(channel_six_diag_pin),
    .channel_on_bits(channel_on_bits), .diag_clear(diag_clear),
    .cmd_valid_seen(cmd_valid_seen));

  always #5 core_clk = ~core_clk;

  // Count clear pulses so a missing or doubled one is seen
  always @(posedge core_clk) begin
    if (diag_clear === 1'b1) dc_cnt <= dc_cnt + 1;
  end

  task automatic cmp(input logic [48:0] got, input logic [48:0] want);
    check_count++;
    if (got !== want) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic set_dflt;
    e_mode = {3{MODE_RST}};
    e_peak = {3{PEAK_RST}};
    e_hold = {3{HOLD_RST}};
    e_off  = {3{OFF_RST}};
    e_pt   = {3{PTIM_RST}};
    {e_low, e_det, e_bool, e_otb, e_pin, e_on} = 15'h0000;
  endtask

  // Expected effect of one accepted frame
  task automatic model(input logic [15:0] f);
    int i;
    i = int'(f[15:12]) - 9;
    e_seen = 1'b1;
    case (f[15:12])
      CMD_REG1, CMD_REG2, CMD_REG3: begin
        e_mode[2*i +: 2] = f[11:10];
        e_peak[2*i +: 2] = f[9:8];
        e_off[2*i +: 2]  = f[7:6];
        e_hold[2*i +: 2] = f[5:4];
        e_pt[3*i +: 3]   = f[3:1];
      end
      CMD_CHCFG: begin
        e_low = {f[11], f[9], f[7]};
        e_det = {f[10], f[8], f[6]};
        {e_bool, e_otb, e_pin} = f[5:3];
      end
      CMD_DEFAULT: set_dflt();
      CMD_SWITCH: e_on = f[11:6];
      default: ;
    endcase
  endtask

  // One frame, then the outputs and the clear pulse count
  task automatic run(input logic [15:0] f, input int n);
    int  pulses;
    logic ok;
    pulses = dc_cnt;
    host.send(f, n);
    repeat (12) @(posedge core_clk); // Covers answer latency and spacing
    ok = (n == 16) && (f[15:12] inside {CMD_REG1, CMD_REG2, CMD_REG3,
      CMD_CHCFG, CMD_DEFAULT, CMD_DIAG, CMD_SWITCH});
    if (ok) model(f);
    cmp(49'(dc_cnt - pulses), 49'(ok));
    cmp(outs, {e_mode, e_peak, e_hold, e_off, e_pt, e_low, e_det,
      e_bool, e_otb, e_pin, e_on, e_seen});
  endtask

  task automatic summarize;
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog far beyond the roughly 24 us the frames need
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end

  initial begin
    set_dflt();
    e_seen = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    cmp(outs, {e_mode, e_peak, e_hold, e_off, e_pt, e_low, e_det,
      e_bool, e_otb, e_pin, e_on, e_seen});
    run(16'h9fce, 16);
    run(16'ha433, 16);
    run(16'hb9a4, 16);
    run(16'hcab8, 16);
    run(16'hc558, 16);
    run(16'hda80, 16);
    run(16'hd57f, 16);
    run(16'hfabc, 16);
    for (int c = 0; c < 8; c++) run({4'(c), 12'h5a5}, 16);
    run(16'he5a5, 16);
    run(16'hd000, 15);
    // A frame that lands while the core is frozen acts only once enabled
    clk_en <= 1'b0;
    p0 = dc_cnt;
    host.send(16'hd540, 16);
    repeat (12) @(posedge core_clk);
    cmp(outs, want_outs);
    cmp(49'(dc_cnt - p0), 49'(0));
    clk_en <= 1'b1;
    repeat (12) @(posedge core_clk);
    model(16'hd540);
    cmp(outs, want_outs);
    cmp(49'(dc_cnt - p0), 49'(1));
    run(16'h8fff, 16);
    summarize();
  end
endmodule
